// ---- hdl/umof_pkg.sv ----
// Contract
// - mixer I/Q sources chosen by channel mode
// - mixer computes rotation; sine inversion selects subtraction in I, addition in Q
// - normal mode passes own I and Q
// - paired mode: A/C real, B/D imaginary
// - paired mode cross Q from B/D I
// - double rate: A real, B imaginary input
// - double rate even pair to A, odd B
// - double rate yields two samples per clock
// - mixer outputs rounded to 21 bits
// - four 16-bit output ports A to D
// - chained sum adds ports C/D input data
// - full rate: new sample every clock
// - half rate interleaves I,Q with marker
// - double rate: even on one port, odd other
// - sum none, pairs or all channels
// - wide resolution merges port pairs, 22 bits
// - rounding code per pair: 12/14/16/22 bits
// - rounded value in MSBs, LSBs cleared
// - offset binary inverts output MSB
package umof_pkg;
  // datapath widths
  localparam int NUM_CH   = 4;
  localparam int SAMP_W   = 18;
  localparam int TRIG_W   = 16;
  localparam int MIX_W    = 21;
  localparam int SUM_W    = 24;
  localparam int WORD_W   = 22;
  localparam int PORT_W   = 16;
  localparam int EXT_LO_W = 6;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 16;
  // mixer accumulator rounding: 35-bit sum down to 21 bits
  localparam int                 MIX_DROP = 14;
  localparam logic signed [34:0] MIX_HALF = 35'h000002000;
  // saturation bounds of the 22-bit formatter word
  localparam logic signed [23:0] WORD_MAX = 24'h1FFFFF;
  localparam logic signed [23:0] WORD_MIN = 24'hE00000;
  // register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ROUND  = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  // control register fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_SUM_LSB    = 2;
  localparam int CTRL_RATE_LSB   = 4;
  localparam int CTRL_CMPLX_BIT  = 6;
  localparam int CTRL_SUMIO_BIT  = 7;
  localparam int CTRL_RES_BIT    = 8;
  localparam int CTRL_INVSIN_BIT = 9;
  localparam int CTRL_OFFBIN_BIT = 10;
  localparam int ROUND_AB_LSB    = 0;
  localparam int ROUND_CD_LSB    = 2;
  // reset values and writable masks
  localparam logic [15:0] CTRL_RESET  = 16'h0210;
  localparam logic [15:0] CTRL_MASK   = 16'h07FF;
  localparam logic [15:0] ROUND_RESET = 16'h0005;
  localparam logic [15:0] ROUND_MASK  = 16'h000F;
  localparam logic [15:0] READ_NONE   = 16'h0000;
  // field encodings
  localparam logic [1:0] MODE_FOUR   = 2'h0;
  localparam logic [1:0] MODE_SPLIT  = 2'h1;
  localparam logic [1:0] MODE_DOUBLE = 2'h2;
  localparam logic [1:0] SUM_NONE    = 2'h0;
  localparam logic [1:0] SUM_PAIRS   = 2'h1;
  localparam logic [1:0] SUM_ALL     = 2'h2;
  localparam logic [1:0] RATE_HALF   = 2'h0;
  localparam logic [1:0] RATE_FULL   = 2'h1;
  localparam logic [1:0] RATE_DOUBLE = 2'h2;
  // rounding codes and the bits kept for each
  localparam logic [1:0] RND_22 = 2'h0;
  localparam logic [1:0] RND_16 = 2'h1;
  localparam logic [1:0] RND_14 = 2'h2;
  localparam logic [1:0] RND_12 = 2'h3;
  localparam int         BITS_22 = 22;
  localparam int         BITS_16 = 16;
  localparam int         BITS_14 = 14;
  localparam int         BITS_12 = 12;
endpackage : umof_pkg

// ---- hdl/umof_formatter.sv ----
// The plain strobed port and the address map are this design's own decisions.
module umof_formatter (
  // clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst_n,
  // register port
  input  wire logic [umof_pkg::ADDR_W-1:0]           regAddr,
  input  wire logic [umof_pkg::DATA_W-1:0]           regWrData,
  input  wire logic                                  regWr,
  input  wire logic                                  regRd,
  output logic      [umof_pkg::DATA_W-1:0]           regRdData,
  // interpolator outputs per channel: I or even, Q or odd
  input  wire logic [3:0][umof_pkg::SAMP_W-1:0]      ownIInput,
  input  wire logic [3:0][umof_pkg::SAMP_W-1:0]      ownQInput,
  // oscillator cosine and sine per channel
  input  wire logic [3:0][umof_pkg::TRIG_W-1:0]      oscCos,
  input  wire logic [3:0][umof_pkg::TRIG_W-1:0]      oscSin,
  // output ports; C and D turn into sum inputs when chained
  output logic      [umof_pkg::PORT_W-1:0]           outPortA,
  output logic      [umof_pkg::PORT_W-1:0]           outPortB,
  output logic      [umof_pkg::PORT_W-1:0]           outPortC,
  output logic      [umof_pkg::PORT_W-1:0]           outPortD,
  output logic                                       outPortCEn,
  output logic                                       outPortDEn,
  input  wire logic [umof_pkg::PORT_W-1:0]           inPortC,
  input  wire logic [umof_pkg::PORT_W-1:0]           inPortD,
  output logic                                       iSampleMarker
);
  import umof_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  logic [DATA_W-1:0] ctrl;
  logic [DATA_W-1:0] roundCtrl;
  logic [1:0]        chMode;
  logic [1:0]        sumMode;
  logic [1:0]        rateMode;
  logic [1:0]        rndAB;
  logic [1:0]        rndCD;
  logic              cmplx;
  logic              sumIo;
  logic              wideRes;
  logic              invSin;
  logic              offsetBin;
  logic              halfPhase;

  // control field decode
  assign chMode    = ctrl[CTRL_MODE_LSB +: 2];
  assign sumMode   = ctrl[CTRL_SUM_LSB +: 2];
  assign rateMode  = ctrl[CTRL_RATE_LSB +: 2];
  assign cmplx     = ctrl[CTRL_CMPLX_BIT];
  assign sumIo     = ctrl[CTRL_SUMIO_BIT];
  assign wideRes   = ctrl[CTRL_RES_BIT];
  assign invSin    = ctrl[CTRL_INVSIN_BIT];
  assign offsetBin = ctrl[CTRL_OFFBIN_BIT];
  assign rndAB     = roundCtrl[ROUND_AB_LSB +: 2];
  assign rndCD     = roundCtrl[ROUND_CD_LSB +: 2];

  // register writes; reserved bits are masked so they read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl      <= CTRL_RESET;
      roundCtrl <= ROUND_RESET;
    end else if (regWr) begin
      if (regAddr == REG_CTRL) begin
        ctrl <= regWrData & CTRL_MASK;
      end
      if (regAddr == REG_ROUND) begin
        roundCtrl <= regWrData & ROUND_MASK;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdData <= READ_NONE;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL:   regRdData <= ctrl;
        REG_ROUND:  regRdData <= roundCtrl;
        REG_STATUS: regRdData <= {13'h0000, outPortCEn, halfPhase,
                                  iSampleMarker};
        default:    regRdData <= READ_NONE;
      endcase
    end else begin
      regRdData <= READ_NONE;
    end
  end

  // ---------------- mixers ----------------
  logic signed [MIX_W-1:0] mixI [NUM_CH];
  logic signed [MIX_W-1:0] mixQ [NUM_CH];

  for (genvar k = 0; k < NUM_CH; k++) begin : g_mix
    localparam int X = k ^ 1;
    logic signed [SAMP_W-1:0] mI;
    logic signed [SAMP_W-1:0] mQ;
    logic signed [33:0]       pIC;
    logic signed [33:0]       pQS;
    logic signed [33:0]       pIS;
    logic signed [33:0]       pQC;
    logic signed [34:0]       accI;
    logic signed [34:0]       accQ;
    logic signed [34:0]       rndI;
    logic signed [34:0]       rndQ;

    // source select: own pair unless paired or double rate cross-straps
    always_comb begin
      mI = $signed(ownIInput[k]);
      mQ = $signed(ownQInput[k]);
      if (chMode == MODE_SPLIT && (k % 2) == 0) begin
        mQ = $signed(ownIInput[X]);
      end
      if (chMode == MODE_DOUBLE) begin
        if ((k % 2) == 0) begin
          mQ = $signed(ownIInput[X]);
        end else begin
          mI = $signed(ownQInput[X]);
        end
      end
    end

    // complex rotation; clear sine inversion gives the conjugate
    assign pIC  = mI * $signed(oscCos[k]);
    assign pQS  = mQ * $signed(oscSin[k]);
    assign pIS  = mI * $signed(oscSin[k]);
    assign pQC  = mQ * $signed(oscCos[k]);
    assign accI = invSin ? 35'(pIC) - 35'(pQS) : 35'(pIC) + 35'(pQS);
    assign accQ = invSin ? 35'(pIS) + 35'(pQC) : 35'(pQC) - 35'(pIS);
    assign rndI = accI + MIX_HALF;
    assign rndQ = accQ + MIX_HALF;

    // round half up to 21 bits; full-scale peaks fit and never wrap
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        mixI[k] <= '0;
        mixQ[k] <= '0;
      end else begin
        mixI[k] <= rndI[MIX_DROP +: MIX_W];
        mixQ[k] <= rndQ[MIX_DROP +: MIX_W];
      end
    end

    AST_SRC_FOUR: assert property (chMode == MODE_FOUR |->
      mI == $signed(ownIInput[k]) && mQ == $signed(ownQInput[k]))
      else $error("mixer source wrong in four-channel mode");
  end

  AST_SRC_SPLIT: assert property (chMode == MODE_SPLIT |->
    g_mix[0].mQ == $signed(ownIInput[1]) &&
    g_mix[2].mQ == $signed(ownIInput[3]))
    else $error("paired mode cross Q not from B/D I");

  AST_SRC_DOUBLE: assert property (chMode == MODE_DOUBLE |->
    g_mix[1].mI == $signed(ownQInput[0]) &&
    g_mix[1].mQ == $signed(ownQInput[1]) &&
    g_mix[0].mQ == $signed(ownIInput[1]))
    else $error("double rate cross-strap wrong");

  AST_MIX_NULL: assert property (oscCos[0] == '0 && oscSin[0] == '0 |=>
    mixI[0] == '0 && mixQ[0] == '0)
    else $error("mixer output not zero for zero oscillator");

  // ---------------- sum tree ----------------
  logic signed [SUM_W-1:0] next_sigI [NUM_CH];
  logic signed [SUM_W-1:0] next_sigQ [NUM_CH];
  logic signed [SUM_W-1:0] sigI [NUM_CH];
  logic signed [SUM_W-1:0] sigQ [NUM_CH];
  logic signed [SUM_W-1:0] mI24 [NUM_CH];
  logic signed [SUM_W-1:0] mQ24 [NUM_CH];
  logic [2:0]              nSig;

  // channel combining; in paired mode the B/D mixers are ignored
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      mI24[k]      = SUM_W'(mixI[k]);
      mQ24[k]      = SUM_W'(mixQ[k]);
      next_sigI[k] = '0;
      next_sigQ[k] = '0;
    end
    nSig = 3'h1;
    if (chMode == MODE_SPLIT) begin
      if (sumMode == SUM_ALL) begin
        next_sigI[0] = mI24[0] + mI24[2];
        next_sigQ[0] = mQ24[0] + mQ24[2];
      end else begin
        next_sigI[0] = mI24[0];
        next_sigQ[0] = mQ24[0];
        next_sigI[1] = mI24[2];
        next_sigQ[1] = mQ24[2];
        nSig         = 3'h2;
      end
    end else if (chMode == MODE_DOUBLE && sumMode == SUM_ALL) begin
      next_sigI[0] = mI24[0] + mI24[2];
      next_sigI[1] = mI24[1] + mI24[3];
      nSig         = 3'h2;
    end else if (sumMode == SUM_ALL) begin
      next_sigI[0] = mI24[0] + mI24[1] + mI24[2] + mI24[3];
      next_sigQ[0] = mQ24[0] + mQ24[1] + mQ24[2] + mQ24[3];
    end else if (sumMode == SUM_PAIRS) begin
      next_sigI[0] = mI24[0] + mI24[1];
      next_sigQ[0] = mQ24[0] + mQ24[1];
      next_sigI[1] = mI24[2] + mI24[3];
      next_sigQ[1] = mQ24[2] + mQ24[3];
      nSig         = 3'h2;
    end else begin
      for (int k = 0; k < NUM_CH; k++) begin
        next_sigI[k] = mI24[k];
        next_sigQ[k] = mQ24[k];
      end
      nSig = 3'h4;
    end
  end

  // sum tree register stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_CH; k++) begin
        sigI[k] <= '0;
        sigQ[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NUM_CH; k++) begin
        sigI[k] <= next_sigI[k];
        sigQ[k] <= next_sigQ[k];
      end
    end
  end

  // ---------------- output formatter ----------------
  function automatic logic [WORD_W-1:0] satWord(
    input logic signed [SUM_W-1:0] v);
    if (v > WORD_MAX) begin
      return WORD_MAX[WORD_W-1:0];
    end else if (v < WORD_MIN) begin
      return WORD_MIN[WORD_W-1:0];
    end
    return v[WORD_W-1:0];
  endfunction : satWord

  // round into the MSBs and clear the dropped LSBs
  function automatic logic [WORD_W-1:0] roundWord(
    input logic [WORD_W-1:0] v,
    input logic [1:0]        code);
    int                 drop;
    logic signed [22:0] t;
    logic [WORD_W-1:0]  r;
    case (code)
      RND_12:  drop = WORD_W - BITS_12;
      RND_14:  drop = WORD_W - BITS_14;
      RND_16:  drop = WORD_W - BITS_16;
      default: drop = WORD_W - BITS_22;
    endcase
    t = 23'($signed(v));
    if (drop > 0) begin
      t = t + (23'h000001 << (drop - 1));
    end
    r = (!t[22] && t[21]) ? WORD_MAX[WORD_W-1:0] : t[WORD_W-1:0];
    return r & ~((22'h000001 << drop) - 22'h000001);
  endfunction : roundWord

  logic signed [SUM_W-1:0]  w [NUM_CH];
  logic [WORD_W-1:0]        rw [NUM_CH];
  logic [PORT_W-1:0]        next_port [NUM_CH];
  logic [PORT_W-1:0]        portWord [NUM_CH];
  logic signed [WORD_W-1:0] extFirst;
  logic signed [WORD_W-1:0] extSecond;
  logic [2:0]               usedW;
  logic                     fullIq;

  assign fullIq    = rateMode == RATE_FULL && cmplx;
  // complex full rate spends two ports per signal, never more than four
  assign usedW     = fullIq ? (nSig == 3'h1 ? 3'h2 : 3'h4) : nSig;
  // chained input arrives MSB-aligned on C, wide LSBs on D
  assign extFirst  = wideRes ? {inPortC, inPortD[PORT_W-1 -: EXT_LO_W]}
                             : {inPortC, 6'h00};
  assign extSecond = {inPortD, 6'h00};

  // word selection, chaining, rounding and port mapping
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      if (rateMode == RATE_HALF) begin
        w[k] = halfPhase ? sigI[k] : sigQ[k];
      end else begin
        w[k] = sigI[k];
      end
    end
    if (fullIq) begin
      w[0] = sigI[0];
      w[1] = sigQ[0];
      w[2] = sigI[1];
      w[3] = sigQ[1];
    end
    if (sumIo) begin
      w[0] = w[0] + SUM_W'(extFirst);
      if (fullIq && !wideRes) begin
        w[1] = w[1] + SUM_W'(extSecond);
      end
    end
    for (int k = 0; k < NUM_CH; k++) begin
      if (3'(k) >= usedW) begin
        w[k] = '0;
      end
      rw[k] = roundWord(satWord(w[k]),
                ((wideRes && k >= 1) || k >= 2) ? rndCD : rndAB);
      next_port[k] = rw[k][WORD_W-1 -: PORT_W];
    end
    if (wideRes) begin
      next_port[0] = rw[0][WORD_W-1 -: PORT_W];
      next_port[1] = {rw[0][EXT_LO_W-1:0], 10'h000};
      next_port[2] = rw[1][WORD_W-1 -: PORT_W];
      next_port[3] = {rw[1][EXT_LO_W-1:0], 10'h000};
    end
    for (int k = 0; k < NUM_CH; k++) begin
      if (offsetBin && !(wideRes && (k % 2) == 1)) begin
        next_port[k][PORT_W-1] = ~next_port[k][PORT_W-1];
      end
    end
  end

  // half-rate phase: I sample first, Q on the next clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      halfPhase <= 1'b1;
    end else if (rateMode == RATE_HALF) begin
      halfPhase <= ~halfPhase;
    end else begin
      halfPhase <= 1'b1;
    end
  end

  // output registers: ports change only on the clock edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_CH; k++) begin
        portWord[k] <= '0;
      end
      iSampleMarker <= 1'b0;
    end else begin
      for (int k = 0; k < NUM_CH; k++) begin
        portWord[k] <= next_port[k];
      end
      iSampleMarker <= rateMode == RATE_HALF && halfPhase;
    end
  end

  assign outPortA   = portWord[0];
  assign outPortB   = portWord[1];
  assign outPortC   = portWord[2];
  assign outPortD   = portWord[3];
  // C and D release the pins while they carry chained input
  assign outPortCEn = !sumIo;
  assign outPortDEn = !sumIo;

  AST_ROUND_ZERO: assert property (rndAB == RND_12 && !wideRes |=>
    outPortA[3:0] == 4'h0 && outPortB[3:0] == 4'h0)
    else $error("12-bit rounding left low bits set");

  AST_HALF_MARK: assert property ((rateMode == RATE_HALF)[*3] |->
    iSampleMarker != $past(iSampleMarker))
    else $error("I marker does not alternate in half rate");

  AST_SUMIO_PORTS: assert property (sumIo && !offsetBin |->
    (!outPortCEn && !outPortDEn) ##1 (outPortC == '0 && outPortD == '0))
    else $error("chained ports still driven");

  AST_OFF_PORTS: assert property (sumMode == SUM_ALL &&
    chMode == MODE_FOUR && rateMode == RATE_FULL && !offsetBin |=>
    outPortC == '0 && outPortD == '0)
    else $error("unused ports not off in sum-all mode");

  AST_WIDE_LSB: assert property (wideRes && !offsetBin |=>
    outPortB[9:0] == 10'h000 && outPortD[9:0] == 10'h000)
    else $error("wide low port carries more than 6 bits");

  AST_OFFBIN: assert property (offsetBin && sumMode == SUM_PAIRS &&
    chMode == MODE_FOUR && rateMode == RATE_FULL && !cmplx && !wideRes |=>
    outPortD == 16'h8000)
    else $error("offset binary MSB not inverted");

  COV_HALF: cover property ((rateMode == RATE_HALF)[*3] ##1 iSampleMarker);
  COV_SPLIT: cover property (chMode == MODE_SPLIT && sumMode == SUM_ALL);
  COV_DOUBLE: cover property (chMode == MODE_DOUBLE &&
    rateMode == RATE_DOUBLE);
  COV_SUMIO: cover property (sumIo && inPortC != '0);
endmodule : umof_formatter

// ---- sim/umof_sum_peer.sv ----
module umof_sum_peer (
  // clock
  input  wire logic        ref_clk,
  // device direction of the shared C and D lines
  input  wire logic        outPortCEn,
  input  wire logic        outPortDEn,
  // word this peer offers into the chain
  input  wire logic [21:0] extWord,
  // peer drive onto the C and D lines
  output logic      [15:0] peerC,
  output logic      [15:0] peerD
);
  timeunit 1ns;
  timeprecision 1ns;

  // start from a busy pattern, never a convenient zero
  initial begin
    peerC = 16'h5A5A;
    peerD = 16'hA5A5;
  end

  // drive only while the device listens; released lines toggle every cycle
  // so a design that reads them at the wrong time cannot pass by chance
  always @(posedge ref_clk) begin
    peerC <= outPortCEn ? ~peerC : extWord[21:6];
    peerD <= outPortDEn ? ~peerD : {extWord[5:0], 10'h000};
  end
endmodule : umof_sum_peer

// ---- sim/upconverter_mixer_output_formatter_tb_top.sv ----
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("unexpected %s: expected %h seen %h", nm, ex, got); \
  end \
end

module upconverter_mixer_output_formatter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import umof_pkg::*;

  logic                    ref_clk;
  logic                    rst_n;
  logic [3:0]              regAddr;
  logic [15:0]             regWrData;
  logic                    regWr;
  logic                    regRd;
  logic [15:0]             regRdData;
  logic [3:0][SAMP_W-1:0]  ownIInput;
  logic [3:0][SAMP_W-1:0]  ownQInput;
  logic [3:0][TRIG_W-1:0]  oscCos;
  logic [3:0][TRIG_W-1:0]  oscSin;
  logic [15:0]             outPortA;
  logic [15:0]             outPortB;
  logic [15:0]             outPortC;
  logic [15:0]             outPortD;
  logic                    outPortCEn;
  logic                    outPortDEn;
  logic [15:0]             inPortC;
  logic [15:0]             inPortD;
  logic                    iSampleMarker;
  logic [15:0]             peerC;
  logic [15:0]             peerD;
  logic [21:0]             extWord;
  int                      n_fail;
  int                      comparisons;
  int                      cyc;

  // the wire carries whoever holds the enable
  assign inPortC = outPortCEn ? outPortC : peerC;
  assign inPortD = outPortDEn ? outPortD : peerD;

  umof_formatter i_umof_formatter (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .ownIInput(ownIInput), .ownQInput(ownQInput),
    .oscCos(oscCos), .oscSin(oscSin), .outPortA(outPortA),
    .outPortB(outPortB), .outPortC(outPortC), .outPortD(outPortD),
    .outPortCEn(outPortCEn), .outPortDEn(outPortDEn), .inPortC(inPortC),
    .inPortD(inPortD), .iSampleMarker(iSampleMarker));

  umof_sum_peer i_umof_sum_peer (
    .ref_clk(ref_clk), .outPortCEn(outPortCEn), .outPortDEn(outPortDEn),
    .extWord(extWord), .peerC(peerC), .peerD(peerD));

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // rotation with the rounding the mixer applies
  function automatic logic signed [23:0] mixf(input logic signed [17:0] i,
      q, input logic signed [15:0] c, s, input logic sub);
    logic signed [34:0] acc;
    acc = sub ? i * c - q * s : i * c + q * s;
    acc = acc + MIX_HALF;
    mixf = $signed(acc[34:14]);
  endfunction : mixf

  // saturate, round half up into the kept MSBs, clear the rest
  function automatic logic [15:0] fmt(input logic signed [23:0] w,
      input logic [1:0] cd);
    int kp;
    logic signed [23:0] r;
    kp = (cd == RND_12) ? BITS_12 : (cd == RND_14) ? BITS_14 :
         (cd == RND_16) ? BITS_16 : BITS_22;
    r = (w > WORD_MAX) ? WORD_MAX : (w < WORD_MIN) ? WORD_MIN : w;
    if (kp < BITS_22) r = r + (24'sh1 <<< (21 - kp));
    if (r > WORD_MAX) r = WORD_MAX;
    r = r & ~((24'sh1 <<< (22 - kp)) - 24'sh1);
    return r[21:6];
  endfunction : fmt

  function automatic logic [15:0] cw(input logic [1:0] md, sm, rt,
      input logic cx, io, wd, inv, ob);
    return 16'(md) | (16'(sm) << CTRL_SUM_LSB) | (16'(rt) << CTRL_RATE_LSB)
      | (16'(cx) << CTRL_CMPLX_BIT) | (16'(io) << CTRL_SUMIO_BIT)
      | (16'(wd) << CTRL_RES_BIT) | (16'(inv) << CTRL_INVSIN_BIT)
      | (16'(ob) << CTRL_OFFBIN_BIT);
  endfunction : cw

  // mixer outputs of channel k's oscillator for chosen sources
  function automatic logic signed [23:0] mi(int k, logic [17:0] i, q);
    return mixf(i, q, oscCos[k], oscSin[k], 1'b1);
  endfunction : mi
  function automatic logic signed [23:0] mq(int k, logic [17:0] i, q);
    return mixf(i, q, oscSin[k], oscCos[k], 1'b0);
  endfunction : mq

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  // let three pipeline stages fill with steady inputs
  task automatic go();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : go

  task automatic t_reset();
    logic [15:0] d;
    rd(REG_CTRL, d);
    `CHK("ctrl reset", CTRL_RESET, d)
    rd(REG_ROUND, d);
    `CHK("round reset", ROUND_RESET, d)
    rd(4'hF, d);
    `CHK("unmapped read", READ_NONE, d)
    rd(REG_STATUS, d);
    `CHK("status reset", 16'h0006, d)
    `CHK("port C drive", 1'b1, outPortCEn)
  endtask : t_reset

  task automatic t_sum();
    logic signed [23:0] a, b, c, d;
    logic [63:0] e;
    a = mi(0, ownIInput[0], ownQInput[0]);
    b = mi(1, ownIInput[1], ownQInput[1]);
    c = mi(2, ownIInput[2], ownQInput[2]);
    d = mi(3, ownIInput[3], ownQInput[3]);
    for (int s = 0; s < 3; s++) begin
      wr(REG_CTRL, cw(MODE_FOUR, 2'(s), RATE_FULL, 0, 0, 0, 1, 0));
      go();
      case (s)
        0: e = {fmt(a, RND_16), fmt(b, RND_16), fmt(c, RND_16),
                fmt(d, RND_16)};
        1: e = {fmt(a + b, RND_16), fmt(c + d, RND_16), 32'h0};
        default: e = {fmt(a + b + c + d, RND_16), 48'h0};
      endcase
      `CHK("summed ports", e, {outPortA, outPortB, outPortC, outPortD})
    end
  endtask : t_sum

  task automatic t_rotate();
    logic [15:0] ea;
    for (int v = 1; v >= 0; v--) begin
      wr(REG_CTRL, cw(MODE_FOUR, SUM_NONE, RATE_FULL, 1, 0, 0, v, 0));
      go();
      ea = fmt(mixf(ownIInput[0], ownQInput[0], oscCos[0], oscSin[0], v),
               RND_16);
      `CHK("mixer I", ea, outPortA)
      ea = fmt(mq(0, ownIInput[0], ownQInput[0]), RND_16);
      if (v == 1) `CHK("mixer Q", ea, outPortB)
    end
  endtask : t_rotate

  task automatic t_round();
    logic [1:0] ab, cd;
    logic [15:0] ea, ec;
    wr(REG_CTRL, cw(MODE_FOUR, SUM_NONE, RATE_FULL, 0, 0, 0, 1, 0));
    for (int n = 0; n < 2; n++) begin
      ab = n ? RND_16 : RND_12;
      cd = n ? RND_12 : RND_14;
      wr(REG_ROUND, 16'({cd, ab}));
      go();
      ea = fmt(mi(0, ownIInput[0], ownQInput[0]), ab);
      ec = fmt(mi(2, ownIInput[2], ownQInput[2]), cd);
      `CHK("round A", ea, outPortA)
      `CHK("round C", ec, outPortC)
    end
    wr(REG_ROUND, ROUND_RESET);
  endtask : t_round

  task automatic t_offbin();
    logic signed [23:0] a;
    a = mi(0, ownIInput[0], ownQInput[0]) + mi(1, ownIInput[1], ownQInput[1]);
    wr(REG_CTRL, cw(MODE_FOUR, SUM_PAIRS, RATE_FULL, 0, 0, 0, 1, 1));
    go();
    `CHK("offset A", fmt(a, RND_16) ^ 16'h8000, outPortA)
    `CHK("offset unused", 16'h8000, outPortD)
  endtask : t_offbin

  task automatic t_half();
    logic m0;
    logic [15:0] ei, eq;
    ei = fmt(mi(0, ownIInput[0], ownQInput[0]), RND_16);
    eq = fmt(mq(0, ownIInput[0], ownQInput[0]), RND_16);
    wr(REG_CTRL, cw(MODE_FOUR, SUM_NONE, RATE_HALF, 1, 0, 0, 1, 0));
    go();
    for (int n = 0; n < 2; n++) begin
      if (n == 1) `CHK("marker toggles", ~m0, iSampleMarker)
      m0 = iSampleMarker;
      `CHK("interleaved A", m0 ? ei : eq, outPortA)
      @(posedge ref_clk);
      #1;
    end
  endtask : t_half

  task automatic t_split();
    logic [15:0] ea, eb, ec;
    ea = fmt(mi(0, ownIInput[0], ownIInput[1]), RND_16);
    eb = fmt(mq(0, ownIInput[0], ownIInput[1]), RND_16);
    ec = fmt(mi(2, ownIInput[2], ownIInput[3]), RND_16);
    wr(REG_CTRL, cw(MODE_SPLIT, SUM_NONE, RATE_FULL, 1, 0, 0, 1, 0));
    go();
    `CHK("split A I", ea, outPortA)
    `CHK("split A Q", eb, outPortB)
    `CHK("split C I", ec, outPortC)
  endtask : t_split

  task automatic t_double();
    logic [15:0] ea, eb;
    ea = fmt(mi(0, ownIInput[0], ownIInput[1]), RND_16);
    eb = fmt(mi(1, ownQInput[0], ownQInput[1]), RND_16);
    wr(REG_CTRL, cw(MODE_DOUBLE, SUM_NONE, RATE_DOUBLE, 0, 0, 0, 1, 0));
    go();
    `CHK("even port", ea, outPortA)
    `CHK("odd port", eb, outPortB)
  endtask : t_double

  task automatic t_chain();
    logic signed [23:0] w;
    w = 24'($signed(extWord));
    for (int k = 0; k < 4; k++) w = w + mi(k, ownIInput[k], ownQInput[k]);
    wr(REG_ROUND, 16'({RND_16, RND_22}));
    wr(REG_CTRL, cw(MODE_FOUR, SUM_ALL, RATE_FULL, 0, 1, 1, 1, 0));
    go();
    `CHK("C released", 1'b0, outPortCEn)
    `CHK("D released", 1'b0, outPortDEn)
    `CHK("wide high", w[21:6], outPortA)
    `CHK("wide low", {w[5:0], 10'h000}, outPortB)
    wr(REG_ROUND, ROUND_RESET);
  endtask : t_chain

  // a new input every clock shows up exactly three edges later
  task automatic t_lat();
    logic [17:0] v [10];
    logic [15:0] ea;
    wr(REG_CTRL, cw(MODE_FOUR, SUM_NONE, RATE_FULL, 0, 0, 0, 1, 0));
    for (int k = 0; k < 10; k++) begin
      @(posedge ref_clk);
      v[k] = 18'(k * 640 + 7);
      ownIInput[0] <= v[k];
      #1;
      if (k >= 3) begin
        ea = fmt(mi(0, v[k - 3], ownQInput[0]), RND_16);
        `CHK("stream A", ea, outPortA)
      end
    end
    // a silent oscillator must give a silent mixer
    @(posedge ref_clk);
    oscCos[0] <= '0;
    oscSin[0] <= '0;
    go();
    `CHK("null mixer", 16'h0000, outPortA)
  endtask : t_lat

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // hang guard, well above the about 136 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    rst_n = 1'b0;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    extWord = 22'h012345;
    ownIInput = {18'h3F555, 18'h00ABC, 18'h3EDCB, 18'h01234};
    ownQInput = {18'h3E222, 18'h01111, 18'h3F888, 18'h00777};
    oscCos = {16'h3C00, 16'h3800, 16'h3400, 16'h2D41};
    oscSin = {16'h0800, 16'hF000, 16'h1800, 16'h2D41};
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_sum();
    t_rotate();
    t_round();
    t_offbin();
    t_half();
    t_split();
    t_double();
    t_chain();
    t_lat();
    end_sim();
  end
endmodule : upconverter_mixer_output_formatter_tb_top
